// *** rtl/ccr_top.sv ***
// Function
// - Speed bit picks high-speed or low-power mode
// - Reference bit picks reference line or pin
// - Channel field routes one of four pins
// - Analog pins read as zero from port
// - Shared register mirrors both results, bits 7:6
// - Both mirrors sampled in the same cycle
// - Shared read leaves mismatch latches untouched
// - Source bit picks programmable or fixed reference
// - Reference line reaches comparator only via reference bit
// - Shared register low nibble reads zero
// - Invert bit flips result before store and pin
// - Drive bit puts result on pin (core enabled, its dir bit clear) or keeps internal
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`include "ccr_cfg.svh"
`default_nettype none

module ccr_top
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        cmp1_raw_in,
    input  wire logic        cmp2_raw_in,
    input  wire logic [7:0]  port_pin_in,
    output logic             cmp1_enable_out,
    output logic             cmp1_speed_sel_out,
    output logic             cmp1_ref_input_sel_out,
    output logic      [1:0]  cmp1_neg_channel_sel_out,
    output logic             cmp1_refsrc_sel_out,
    output logic             cmp1_pin_out,
    output logic             cmp1_pin_oe_n_out,
    output logic             cmp2_enable_out,
    output logic             cmp2_speed_sel_out,
    output logic             cmp2_ref_input_sel_out,
    output logic      [1:0]  cmp2_neg_channel_sel_out,
    output logic             cmp2_refsrc_sel_out,
    output logic             cmp2_pin_out,
    output logic             cmp2_pin_oe_n_out,
    output logic             irq_out
);

    ccr_pkg::ccr_top_s st_r;
    ccr_pkg::ccr_top_s st_nxt;

    logic       req;
    logic       wr_lo;
    logic       rd;
    logic       cmp1_result;
    logic       cmp2_result;
    logic [1:0] evt;
    logic [1:0] latch_upd;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic       clr_wr;
    logic       mask_wr;

    // One request per bus cycle; the ack cycle itself is not a new request
    assign req   = wb_cyc_in & wb_stb_in & ~st_r.ack;
    // No register is wider than eight bits, so only lane 0 carries data
    assign wr_lo = req & wb_we_in & wb_sel_in[0];
    assign rd    = req & ~wb_we_in;

    // Only a control register read refreshes a mismatch latch
    assign latch_upd[0] = rd && (wb_adr_in == `CCR_OFF_CTRL1);
    assign latch_upd[1] = rd && (wb_adr_in == `CCR_OFF_CTRL2);

    assign clr_wr  = wr_lo && (wb_adr_in == `CCR_OFF_IRQ_STAT);
    assign mask_wr = wr_lo && (wb_adr_in == `CCR_OFF_IRQ_MASK);

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ack = req;
        if (wr_lo)
        begin
            case (wb_adr_in)
                `CCR_OFF_CTRL1:
                begin
                    st_nxt.ctrl1 = wb_dat_in[7:0];
                end
                `CCR_OFF_CTRL2:
                begin
                    st_nxt.ctrl2 = wb_dat_in[7:0];
                end
                `CCR_OFF_SHARED:
                begin
                    // Mirror bits are read only; low nibble has no storage
                    st_nxt.refsrc = {wb_dat_in[`CCR_SHR_REFSRC1],
                                     wb_dat_in[`CCR_SHR_REFSRC2]};
                end
                `CCR_OFF_DIR:
                begin
                    st_nxt.dir = wb_dat_in[7:0];
                end
                `CCR_OFF_ANSEL:
                begin
                    st_nxt.ansel = wb_dat_in[7:0];
                end
                default:
                begin
                    st_nxt.dir = st_r.dir;
                end
            endcase
        end
        if (rd)
        begin
            st_nxt.rdat = 32'h0000_0000;
            case (wb_adr_in)
                `CCR_OFF_CTRL1:
                begin
                    st_nxt.rdat[7:0] = st_r.ctrl1;
                    st_nxt.rdat[`CCR_CTL_RESULT] = cmp1_result;
                end
                `CCR_OFF_CTRL2:
                begin
                    st_nxt.rdat[7:0] = st_r.ctrl2;
                    st_nxt.rdat[`CCR_CTL_RESULT] = cmp2_result;
                end
                `CCR_OFF_SHARED:
                begin
                    // Both mirrors come from flops of the same edge
                    st_nxt.rdat[`CCR_SHR_MIRROR1] = cmp1_result;
                    st_nxt.rdat[`CCR_SHR_MIRROR2] = cmp2_result;
                    st_nxt.rdat[`CCR_SHR_REFSRC1] = st_r.refsrc[1];
                    st_nxt.rdat[`CCR_SHR_REFSRC2] = st_r.refsrc[0];
                    st_nxt.rdat[3:0] = 4'h0;
                end
                `CCR_OFF_PORT:
                begin
                    st_nxt.rdat[7:0] = port_pin_in & ~st_r.ansel;
                end
                `CCR_OFF_DIR:
                begin
                    st_nxt.rdat[7:0] = st_r.dir;
                end
                `CCR_OFF_ANSEL:
                begin
                    st_nxt.rdat[7:0] = st_r.ansel;
                end
                `CCR_OFF_IRQ_STAT:
                begin
                    st_nxt.rdat[1:0] = irq_stat;
                end
                `CCR_OFF_IRQ_MASK:
                begin
                    st_nxt.rdat[1:0] = irq_mask;
                end
                default:
                begin
                    st_nxt.rdat = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_r.ctrl1  <= `CCR_CTRL_RST;
            st_r.ctrl2  <= `CCR_CTRL_RST;
            st_r.refsrc <= `CCR_REFSRC_RST;
            st_r.dir    <= `CCR_DIR_RST;
            st_r.ansel  <= `CCR_ANSEL_RST;
            st_r.ack    <= 1'b0;
            st_r.rdat   <= 32'h0000_0000;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ccr_chan u_chan1
    (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .raw_in       (cmp1_raw_in),
        .enable_in    (st_r.ctrl1[`CCR_CTL_ENABLE]),
        .invert_in    (st_r.ctrl1[`CCR_CTL_INVERT]),
        .drive_en_in  (st_r.ctrl1[`CCR_CTL_DRIVE]),
        .dir_in       (st_r.dir[`CCR_PIN_CMP1]),
        .latch_upd_in (latch_upd[0]),
        .result_out   (cmp1_result),
        .evt_out      (evt[0]),
        .pin_out      (cmp1_pin_out),
        .pin_oe_n_out (cmp1_pin_oe_n_out)
    );

    ccr_chan u_chan2
    (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .raw_in       (cmp2_raw_in),
        .enable_in    (st_r.ctrl2[`CCR_CTL_ENABLE]),
        .invert_in    (st_r.ctrl2[`CCR_CTL_INVERT]),
        .drive_en_in  (st_r.ctrl2[`CCR_CTL_DRIVE]),
        .dir_in       (st_r.dir[`CCR_PIN_CMP2]),
        .latch_upd_in (latch_upd[1]),
        .result_out   (cmp2_result),
        .evt_out      (evt[1]),
        .pin_out      (cmp2_pin_out),
        .pin_oe_n_out (cmp2_pin_oe_n_out)
    );

    ccr_irq u_irq
    (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .set_in     (evt),
        .clr_wr_in  (clr_wr),
        .mask_wr_in (mask_wr),
        .wdat_in    (wb_dat_in[1:0]),
        .stat_out   (irq_stat),
        .mask_out   (irq_mask),
        .irq_out    (irq_out)
    );

    assign wb_dat_out = st_r.rdat;
    assign wb_ack_out = st_r.ack;

    // Analog controls come straight from the register flops
    assign cmp1_enable_out          = st_r.ctrl1[`CCR_CTL_ENABLE];
    assign cmp1_speed_sel_out       = st_r.ctrl1[`CCR_CTL_SPEED];
    assign cmp1_ref_input_sel_out   = st_r.ctrl1[`CCR_CTL_REFIN];
    assign cmp1_neg_channel_sel_out =
        st_r.ctrl1[`CCR_CTL_CHAN_HI:`CCR_CTL_CHAN_LO];
    assign cmp1_refsrc_sel_out      = st_r.refsrc[1];
    assign cmp2_enable_out          = st_r.ctrl2[`CCR_CTL_ENABLE];
    assign cmp2_speed_sel_out       = st_r.ctrl2[`CCR_CTL_SPEED];
    assign cmp2_ref_input_sel_out   = st_r.ctrl2[`CCR_CTL_REFIN];
    assign cmp2_neg_channel_sel_out =
        st_r.ctrl2[`CCR_CTL_CHAN_HI:`CCR_CTL_CHAN_LO];
    assign cmp2_refsrc_sel_out      = st_r.refsrc[0];

    wb_ack_pulse_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
        else $error("ack not a single cycle after request");

    speed_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (wr_lo && wb_adr_in == 8'h04)
        |=> cmp2_speed_sel_out == $past(wb_dat_in[3]))
        else $error("speed select not taken from write");

    ref_input_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (wr_lo && wb_adr_in == 8'h04)
        |=> cmp2_ref_input_sel_out == $past(wb_dat_in[2]))
        else $error("reference input select not taken from write");

    neg_channel_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (wr_lo && wb_adr_in == 8'h04)
        |=> cmp2_neg_channel_sel_out == $past(wb_dat_in[1:0]))
        else $error("channel select not taken from write");

    port_analog_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (rd && wb_adr_in == 8'h0c)
        |=> wb_dat_out[7:0] == ($past(port_pin_in) & ~st_r.ansel))
        else $error("analog pin did not read as zero");

    mirror_read_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (rd && wb_adr_in == 8'h08)
        |=> wb_dat_out[7:6] == {$past(cmp1_result), $past(cmp2_result)})
        else $error("mirror bits differ from results");

    shared_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (rd && wb_adr_in == 8'h08) |=> wb_dat_out[3:0] == 4'h0)
        else $error("shared register low nibble not zero");

    refsrc_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (wr_lo && wb_adr_in == 8'h08)
        |=> {cmp1_refsrc_sel_out, cmp2_refsrc_sel_out}
            == $past(wb_dat_in[5:4]))
        else $error("reference source select not taken from write");

    latch_keep_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (rd && wb_adr_in == 8'h08) |-> latch_upd == 2'h0)
        else $error("shared read touched a mismatch latch");

endmodule : ccr_top

`default_nettype wire

// *** pkg/ccr_cfg.svh ***
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// Register byte offsets on the Wishbone word bus
`define CCR_OFF_CTRL1     8'h00
`define CCR_OFF_CTRL2     8'h04
`define CCR_OFF_SHARED    8'h08
`define CCR_OFF_PORT      8'h0c
`define CCR_OFF_DIR       8'h10
`define CCR_OFF_ANSEL     8'h14
`define CCR_OFF_IRQ_STAT  8'h18
`define CCR_OFF_IRQ_MASK  8'h1c

// Comparator control register fields
`define CCR_CTL_ENABLE    7
`define CCR_CTL_RESULT    6
`define CCR_CTL_DRIVE     5
`define CCR_CTL_INVERT    4
`define CCR_CTL_SPEED     3
`define CCR_CTL_REFIN     2
`define CCR_CTL_CHAN_HI   1
`define CCR_CTL_CHAN_LO   0

// Shared status and reference source register fields
`define CCR_SHR_MIRROR1   7
`define CCR_SHR_MIRROR2   6
`define CCR_SHR_REFSRC1   5
`define CCR_SHR_REFSRC2   4

// Pins that carry the comparator outputs
`define CCR_PIN_CMP1      0
`define CCR_PIN_CMP2      1

// Reset values
`define CCR_CTRL_RST      8'h00
`define CCR_REFSRC_RST    2'h0
`define CCR_DIR_RST       8'hff
`define CCR_ANSEL_RST     8'hff
`define CCR_MASK_RST      2'h0
`define CCR_STAT_RST      2'h0

`endif

// *** pkg/ccr_pkg.sv ***
`default_nettype none

package ccr_pkg;

    typedef struct packed {
        logic        result;
        logic        latch;
        logic        evt;
        logic        pin_out;
        logic        pin_oe_n;
    } ccr_chan_s;

    typedef struct packed {
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic        irq;
    } ccr_irq_s;

    typedef struct packed {
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic [1:0]  refsrc;
        logic [7:0]  dir;
        logic [7:0]  ansel;
        logic        ack;
        logic [31:0] rdat;
    } ccr_top_s;

endpackage : ccr_pkg

`default_nettype wire

// *** rtl/ccr_chan.sv ***
`default_nettype none

module ccr_chan
(
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    input  wire logic raw_in,
    input  wire logic enable_in,
    input  wire logic invert_in,
    input  wire logic drive_en_in,
    input  wire logic dir_in,
    input  wire logic latch_upd_in,
    output logic      result_out,
    output logic      evt_out,
    output logic      pin_out,
    output logic      pin_oe_n_out
);

    ccr_pkg::ccr_chan_s st_r;
    ccr_pkg::ccr_chan_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        // Disabled comparator reads back as zero
        st_nxt.result = enable_in & (raw_in ^ invert_in);
        // Mismatch latch follows only a read of the control register
        if (latch_upd_in)
        begin
            st_nxt.latch = st_r.result;
        end
        st_nxt.evt = (st_r.result != st_r.latch);
        st_nxt.pin_out = st_nxt.result;
        st_nxt.pin_oe_n = ~(drive_en_in & enable_in & ~dir_in);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_r <= '0;
            st_r.pin_oe_n <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign result_out   = st_r.result;
    assign evt_out      = st_r.evt;
    assign pin_out      = st_r.pin_out;
    assign pin_oe_n_out = st_r.pin_oe_n;

    pin_drive_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (drive_en_in && enable_in && !dir_in) |=> !pin_oe_n_out ##0
        (pin_out == result_out))
        else $error("pin not driven when all three enables hold");

    pin_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !(drive_en_in && enable_in && !dir_in) |=> pin_oe_n_out)
        else $error("pin driven while an enable is off");

    invert_res_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (enable_in && invert_in) |=> result_out == !$past(raw_in))
        else $error("inverted result wrong");

    change_evt_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (result_out != $past(result_out)) && !$past(latch_upd_in)
        && ($past(result_out) == st_r.latch) |=> evt_out)
        else $error("output change raised no event");

endmodule : ccr_chan

`default_nettype wire

// *** rtl/ccr_irq.sv ***
`include "ccr_cfg.svh"
`default_nettype none

module ccr_irq
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [1:0] set_in,
    input  wire logic       clr_wr_in,
    input  wire logic       mask_wr_in,
    input  wire logic [1:0] wdat_in,
    output logic      [1:0] stat_out,
    output logic      [1:0] mask_out,
    output logic            irq_out
);

    ccr_pkg::ccr_irq_s st_r;
    ccr_pkg::ccr_irq_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (clr_wr_in)
        begin
            st_nxt.stat = st_r.stat & ~wdat_in;
        end
        // Set after clear so an event in the clearing cycle is kept
        st_nxt.stat = st_nxt.stat | set_in;
        if (mask_wr_in)
        begin
            st_nxt.mask = wdat_in;
        end
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_r <= {`CCR_STAT_RST, `CCR_MASK_RST, 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign stat_out = st_r.stat;
    assign mask_out = st_r.mask;
    assign irq_out  = st_r.irq;

    set_wins_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (set_in != 2'h0) |=> ((stat_out & $past(set_in)) == $past(set_in)))
        else $error("event lost against a clear");

    irq_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (mask_out == 2'h0) && !mask_wr_in |=> !irq_out)
        else $error("interrupt raised while fully masked");

endmodule : ccr_irq

`default_nettype wire

// *** sim/ccr_analog_model.sv ***
`default_nettype none

module ccr_analog_model
#(
    parameter logic [11:0] FIXED_MV = 12'h4b0
)
(
    input  wire logic [1:0]       enable_in,
    input  wire logic [1:0]       ref_input_sel_in,
    input  wire logic [1:0]       refsrc_sel_in,
    input  wire logic [3:0]       neg_channel_sel_in,
    input  wire logic [1:0]       pin_out_in,
    input  wire logic [1:0]       pin_oe_n_in,
    input  wire logic [1:0][11:0] pos_mv_in,
    input  wire logic [3:0][11:0] neg_mv_in,
    input  wire logic [11:0]      prog_mv_in,
    input  wire logic [7:0]       pad_in,
    output logic      [1:0]       raw_out,
    output logic      [7:0]       pin_level_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [11:0] ref_mv;
    logic [11:0] plus_mv;

    // Levels in millivolts; a disabled core reports 0 so no stale edge leaks
    always_comb
    begin
        ref_mv = 12'h000;
        plus_mv = 12'h000;
        for (int i = 0; i < 2; i++)
        begin
            ref_mv = refsrc_sel_in[i] ? prog_mv_in : FIXED_MV;
            plus_mv = ref_input_sel_in[i] ? ref_mv : pos_mv_in[i];
            raw_out[i] = enable_in[i] &
                (plus_mv > neg_mv_in[neg_channel_sel_in[2*i+:2]]);
        end
    end

    // Pins 0 and 1 follow the comparator only while it drives them
    always_comb
    begin
        pin_level_out = pad_in;
        for (int i = 0; i < 2; i++)
        begin
            if (!pin_oe_n_in[i])
                pin_level_out[i] = pin_out_in[i];
        end
    end
endmodule : ccr_analog_model

`default_nettype wire

// *** sim/ccr_top_tb.sv ***
`include "ccr_cfg.svh"
`default_nettype none

module ccr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic [7:0]       adr = 8'h00;
    logic [3:0]       sel = 4'h1;
    logic [31:0]      wdat = 32'h0;
    logic [31:0]      rdat;
    logic             ack;
    logic [1:0]       raw;
    logic [7:0]       pins;
    logic [1:0]       en, spd, rin, rs, po, poe;
    logic [3:0]       ch;
    logic             irq;
    logic [1:0][11:0] pos_mv = {12'h2bc, 12'h2bc};
    logic [3:0][11:0] neg_mv = {12'h514, 12'h384, 12'h1f4, 12'h064};
    logic [11:0]      prog_mv = 12'h190;
    logic [7:0]       pad = 8'h5c;
    int               fail_count = 0;
    int               samples_checked = 0;
    int               cycles = 0;

    always #2.5 clk = ~clk;

    ccr_top ccr_top_inst
    (
        .sys_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .cmp1_raw_in(raw[0]), .cmp2_raw_in(raw[1]),
        .port_pin_in(pins), .cmp1_enable_out(en[0]),
        .cmp1_speed_sel_out(spd[0]), .cmp1_ref_input_sel_out(rin[0]),
        .cmp1_neg_channel_sel_out(ch[1:0]), .cmp1_refsrc_sel_out(rs[0]),
        .cmp1_pin_out(po[0]), .cmp1_pin_oe_n_out(poe[0]),
        .cmp2_enable_out(en[1]), .cmp2_speed_sel_out(spd[1]),
        .cmp2_ref_input_sel_out(rin[1]),
        .cmp2_neg_channel_sel_out(ch[3:2]), .cmp2_refsrc_sel_out(rs[1]),
        .cmp2_pin_out(po[1]), .cmp2_pin_oe_n_out(poe[1]), .irq_out(irq)
    );

    ccr_analog_model ccr_analog_model_inst
    (
        .enable_in(en), .ref_input_sel_in(rin), .refsrc_sel_in(rs),
        .neg_channel_sel_in(ch), .pin_out_in(po), .pin_oe_n_in(poe),
        .pos_mv_in(pos_mv), .neg_mv_in(neg_mv), .prog_mv_in(prog_mv),
        .pad_in(pad), .raw_out(raw), .pin_level_out(pins)
    );

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked,
                 fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // Hang guard: the whole sequence needs well under 2000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk

    // Entered just after an edge; holds the request until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask : rd_chk

    // Covers result, event, status and irq register stages
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask : settle

    task automatic t_reset;
        chk("oe_n", 8'h03, {6'h0, poe});
        chk("ctl_outs", 8'h00, {en, spd, rin, rs});
        rd_chk("ctrl1", `CCR_OFF_CTRL1, 8'h00);
        rd_chk("ctrl2", `CCR_OFF_CTRL2, 8'h00);
        rd_chk("shared", `CCR_OFF_SHARED, 8'h00);
        rd_chk("dir", `CCR_OFF_DIR, 8'hff);
        rd_chk("ansel", `CCR_OFF_ANSEL, 8'hff);
        rd_chk("mask", `CCR_OFF_IRQ_MASK, 8'h00);
        sel <= 4'he;
        wr(`CCR_OFF_CTRL1, 8'hff);
        sel <= 4'h1;
        rd_chk("lane", `CCR_OFF_CTRL1, 8'h00);
        wr(8'h40, 8'hff);
        rd_chk("unmapped", 8'h40, 8'h00);
    endtask : t_reset

    // Every channel, input select, source select and speed, both cores
    task automatic t_fields;
        logic [7:0]  a, c;
        logic [3:0]  mm;
        logic [11:0] plus;
        logic        e;
        for (int k = 0; k < 2; k++)
            for (int m = 0; m < 16; m++)
            begin
                mm = m[3:0];
                a = k ? `CCR_OFF_CTRL2 : `CCR_OFF_CTRL1;
                c = {4'h8, mm[0], mm[2], mm[1:0]};
                wr(a, c);
                wr(`CCR_OFF_SHARED, k ? {3'h0, mm[3], 4'h0}
                                      : {2'h0, mm[3], 5'h00});
                plus = mm[2] ? (mm[3] ? prog_mv : 12'h4b0) : pos_mv[k];
                e = plus > neg_mv[mm[1:0]];
                settle();
                rd_chk("ctrl", a, c | {1'b0, e, 6'h00});
                chk("sel", {mm[0], mm[2], mm[1:0], mm[3], 3'h0},
                    {spd[k], rin[k], ch[2*k+:2], rs[k], 3'h0});
            end
    endtask : t_fields

    task automatic t_pin;
        wr(`CCR_OFF_CTRL1, 8'ha0);
        wr(`CCR_OFF_CTRL2, 8'ha0);
        wr(`CCR_OFF_DIR, 8'hfc);
        wr(`CCR_OFF_ANSEL, 8'h00);
        settle();
        chk("oe_n", 8'h00, {6'h0, poe});
        chk("pin", 8'h03, {6'h0, po});
        chk("en", 8'h03, {6'h0, en});
        rd_chk("port", `CCR_OFF_PORT, {pad[7:2], 2'h3});
        wr(`CCR_OFF_CTRL2, 8'hb0);
        settle();
        rd_chk("ctrl2", `CCR_OFF_CTRL2, 8'hb0);
        rd_chk("port", `CCR_OFF_PORT, {pad[7:2], 2'h1});
        wr(`CCR_OFF_DIR, 8'hff);
        settle();
        chk("oe_n2", 8'h01, {7'h0, poe[1]});
        wr(`CCR_OFF_DIR, 8'hfd);
        wr(`CCR_OFF_CTRL2, 8'h90);
        settle();
        chk("oe_n2", 8'h01, {7'h0, poe[1]});
        wr(`CCR_OFF_CTRL2, 8'h20);
        settle();
        chk("oe_n2", 8'h01, {7'h0, poe[1]});
    endtask : t_pin

    task automatic t_analog;
        wr(`CCR_OFF_ANSEL, 8'hff);
        rd_chk("port", `CCR_OFF_PORT, 8'h00);
        wr(`CCR_OFF_ANSEL, 8'h0f);
        rd_chk("port", `CCR_OFF_PORT, {pad[7:4], 4'h0});
    endtask : t_analog

    task automatic t_shared;
        wr(`CCR_OFF_CTRL1, 8'h80);
        wr(`CCR_OFF_CTRL2, 8'h83);
        wr(`CCR_OFF_SHARED, 8'hff);
        settle();
        rd_chk("shared", `CCR_OFF_SHARED, 8'hb0);
        chk("refsrc", 8'h03, {6'h0, rs});
        pos_mv <= {12'h578, 12'h032};
        settle();
        rd_chk("shared", `CCR_OFF_SHARED, 8'h70);
    endtask : t_shared

    task automatic t_irq;
        logic [7:0] q;
        xfer(1'b0, `CCR_OFF_CTRL1, 8'h00, q);
        xfer(1'b0, `CCR_OFF_CTRL2, 8'h00, q);
        wr(`CCR_OFF_IRQ_STAT, 8'h03);
        settle();
        rd_chk("stat", `CCR_OFF_IRQ_STAT, 8'h00);
        pos_mv <= {12'h578, 12'h2bc};
        settle();
        rd_chk("stat", `CCR_OFF_IRQ_STAT, 8'h01);
        chk("irq", 8'h00, {7'h0, irq});
        wr(`CCR_OFF_IRQ_MASK, 8'h01);
        settle();
        chk("irq", 8'h01, {7'h0, irq});
        xfer(1'b0, `CCR_OFF_SHARED, 8'h00, q);
        wr(`CCR_OFF_IRQ_STAT, 8'h01);
        settle();
        rd_chk("stat", `CCR_OFF_IRQ_STAT, 8'h01);
        xfer(1'b0, `CCR_OFF_CTRL1, 8'h00, q);
        wr(`CCR_OFF_IRQ_STAT, 8'h01);
        settle();
        rd_chk("stat", `CCR_OFF_IRQ_STAT, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        wr(`CCR_OFF_IRQ_MASK, 8'h03);
        pos_mv <= {12'h2bc, 12'h2bc};
        settle();
        chk("irq", 8'h01, {7'h0, irq});
        rd_chk("stat", `CCR_OFF_IRQ_STAT, 8'h02);
        xfer(1'b0, `CCR_OFF_CTRL2, 8'h00, q);
        wr(`CCR_OFF_IRQ_STAT, 8'h02);
        settle();
        chk("irq", 8'h00, {7'h0, irq});
    endtask : t_irq

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_fields();
        t_pin();
        t_analog();
        t_shared();
        t_irq();
        wrap_up();
    end
endmodule : ccr_top_tb

`default_nettype wire
